// >>> rtl/led_ctrl_pkg.sv
// constants shared by the colour controller register bank
// assumes one 125 MHz clock and a byte-wide register port fed by a serial slave
// Function
// - duty-update command loads red, green, blue widths when modulator enabled, open loop
// - calibration store writes 50 bytes to eeprom, polarity only, then clears
// - auto gain runs in open loop; host enables pwm and constant first
// - capture offsets measures each channel into x, y, z offsets, then clears
// - capture readings acquires three channels into results, clears when all done
// - compute calibration starts computation, clears bit when finished
// - self download set loads registers from eeprom after a soft reset; hardware reset clears the bit, so none at power up
// - self download with stored modulator enable also applies stored colour point
// - polarity bit one makes pwm outputs active low, zero active high
// - modulator enable one runs pwm generator, zero turns leds off
// - open loop select one chooses open loop, zero feedback; resets zero
// - mode flags show open loop or feedback mode; feedback reads one after reset
// - initialization flag reads one while initializing, zero when done
// - acquisition fail flag set when acquisition cannot complete, else zero
// - eeprom fault flag set on missing acknowledge or failed exchange
// - dim and bright flags report light too dim or too bright
// - unlocked flag reads one while set point cannot be reached
// - out of range set point sets flag and keeps previous valid point
// - pwm frequency is clock over (divider plus one) times 4096
// - sampling frequency is clock over eight times 16-bit divider
// - command register sits at fixed address and resets to zero
package led_ctrl_pkg;
  // register addresses
  localparam logic [7:0] addr_open_loop_commands = 8'h02;
  localparam logic [7:0] addr_output_config = 8'h03;
  localparam logic [7:0] addr_loop_mode_select = 8'h04;
  localparam logic [7:0] addr_pwm_rate_divider = 8'h05;
  localparam logic [7:0] addr_sample_divider_low = 8'h06;
  localparam logic [7:0] addr_sample_divider_high = 8'h07;
  localparam logic [7:0] addr_mode_flags = 8'h22;
  localparam logic [7:0] addr_fault_flags = 8'h23;
  localparam logic [7:0] addr_acquisition_constant = 8'ha9;
  // reset values
  localparam logic [7:0] rst_open_loop_commands = 8'h00;
  localparam logic [7:0] rst_output_config = 8'h00;
  localparam logic [7:0] rst_loop_mode_select = 8'h00;
  localparam logic [7:0] rst_pwm_rate_divider = 8'h00;
  localparam logic [7:0] rst_sample_divider_low = 8'h30;
  localparam logic [7:0] rst_sample_divider_high = 8'h75;
  localparam logic [7:0] rst_mode_flags = 8'h02;
  localparam logic [7:0] rst_acquisition_constant = 8'h00;
  // command register bits
  localparam int bit_apply_duty = 7;
  localparam int bit_cal_store = 4;
  localparam int bit_auto_gain = 3;
  localparam int bit_capture_offsets = 2;
  localparam int bit_capture_readings = 1;
  localparam int bit_compute_cal = 0;
  localparam logic [7:0] cmd_write_mask = 8'h9f;
  // output_config bits
  localparam int bit_modulator_enable = 0;
  localparam int bit_output_polarity = 1;
  localparam int bit_self_download_en = 2;
  localparam logic [7:0] config_write_mask = 8'h07;
  // fault_flags bits
  localparam int bit_out_of_range = 0;
  localparam int bit_setpoint_unlocked = 1;
  localparam int bit_too_bright = 3;
  localparam int bit_too_dim = 4;
  localparam int bit_eeprom_fault = 5;
  localparam int bit_acquisition_fail = 7;
  // timing
  localparam int pwm_counts_per_period = 4096;
  localparam int sample_prescale = 8;
  localparam int cal_store_bytes = 50;
  localparam int acq_const_max = 9;
endpackage : led_ctrl_pkg

// >>> rtl/pwm_channel.sv
// one pwm output channel with polarity and enable
// assumes a shared period counter from the parent
`timescale 1ns/1ps
`default_nettype none
module pwm_channel
  import led_ctrl_pkg::*;
#(
  parameter int width = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // control
  input wire logic [width-1:0] phase,
  input wire logic [width-1:0] duty,
  input wire logic enable,
  input wire logic active_low,
  // pin
  output logic pulse
);
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      pulse <= 1'b0;
    else if (!enable)
      pulse <= active_low;
    else
      pulse <= (phase < duty) ^ active_low;
  end
endmodule : pwm_channel
`default_nettype wire

// >>> rtl/led_color_ctrl_cmd_status.sv
// command, configuration, status and fault registers of the colour controller
// assumes a byte register port (address, write strobe, read strobe) from a serial slave;
// the sensor front end, eeprom engine and calibration engine are outside and
// answer each start with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module led_color_ctrl_cmd_status
  import led_ctrl_pkg::*;
#(
  parameter int duty_width = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // software reset request from the control register
  input wire logic soft_reset,
  // duty values for open loop
  input wire logic [duty_width-1:0] red_duty,
  input wire logic [duty_width-1:0] green_duty,
  input wire logic [duty_width-1:0] blue_duty,
  // eeprom engine
  output logic cal_store_start,
  output logic self_download_start,
  output logic colour_point_fetch,
  input wire logic eeprom_done,
  input wire logic eeprom_ack_fail,
  input wire logic stored_modulator_enable,
  input wire logic stored_polarity,
  // sensor and calibration engines
  output logic auto_gain_start,
  output logic capture_offsets_start,
  output logic capture_readings_start,
  output logic compute_cal_start,
  input wire logic auto_gain_done,
  input wire logic capture_offsets_done,
  input wire logic capture_readings_done,
  input wire logic compute_cal_done,
  input wire logic acquisition_ok,
  input wire logic acquisition_failed,
  // loop status from the feedback engine
  input wire logic light_dim,
  input wire logic light_bright,
  input wire logic setpoint_unlocked,
  input wire logic setpoint_out_of_range,
  // rate strobes
  output logic pwm_period_tick,
  output logic sample_tick,
  output logic [15:0] sample_divider,
  output logic [7:0] acquisition_constant,
  // pins
  output logic red_pulse_out,
  output logic green_pulse_out,
  output logic blue_pulse_out
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [1:0] {st_boot, st_download, st_run} init_state_e;
  init_state_e init_state;
  logic [7:0] open_loop_commands;
  logic [7:0] output_config;
  logic [7:0] loop_mode_select;
  logic [7:0] pwm_rate_divider;
  logic [7:0] fault_flags;
  logic open_loop_select;
  logic modulator_enable;
  logic output_polarity;
  logic self_download_en;
  logic init_flag;
  logic cmd_write;
  logic [7:0] next_commands;
  logic [7:0] cmd_done;
  logic [7:0] start_edges;
  logic [duty_width-1:0] red_width;
  logic [duty_width-1:0] green_width;
  logic [duty_width-1:0] blue_width;
  logic [11:0] pwm_phase;
  logic [7:0] pwm_prescale;
  logic [18:0] sample_count;
  logic cal_store_busy;

  assign open_loop_select = loop_mode_select[0];
  assign modulator_enable = output_config[bit_modulator_enable];
  assign output_polarity = output_config[bit_output_polarity];
  assign self_download_en = output_config[bit_self_download_en];
  assign cmd_write = reg_write && (reg_addr == addr_open_loop_commands);

  // rising edges of command bits 0 to 4 become start pulses; the duty update bit has none
  function automatic logic [7:0] set_edges(input logic [7:0] old_v, input logic [7:0] new_v);
    set_edges = new_v & ~old_v;
  endfunction : set_edges

  // ****************************************************************
  // initialization and self download
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      init_state <= st_boot;
    else if (soft_reset)
      init_state <= st_boot;
    else
    begin
      case (init_state)
        st_boot:
          init_state <= self_download_en ? st_download : st_run;
        st_download:
          if (eeprom_done)
            init_state <= st_run;
        default:
          init_state <= st_run;
      endcase
    end
  end

  assign init_flag = (init_state != st_run);
  assign self_download_start = (init_state == st_boot) && self_download_en;
  // stored enable high means the colour point is fetched too
  assign colour_point_fetch = (init_state == st_download) && eeprom_done
    && stored_modulator_enable;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      output_config <= rst_output_config;
    else if (init_state == st_download && eeprom_done)
    begin
      output_config <= rst_output_config;
      output_config[bit_output_polarity] <= stored_polarity;
      output_config[bit_modulator_enable] <= stored_modulator_enable;
      output_config[bit_self_download_en] <= 1'b1;
    end
    else if (reg_write && reg_addr == addr_output_config)
      output_config <= reg_wdata & config_write_mask;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      loop_mode_select <= rst_loop_mode_select;
    else if (reg_write && reg_addr == addr_loop_mode_select)
      loop_mode_select <= {7'h00, reg_wdata[0]};
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pwm_rate_divider <= rst_pwm_rate_divider;
      sample_divider <= {rst_sample_divider_high, rst_sample_divider_low};
      acquisition_constant <= rst_acquisition_constant;
    end
    else if (reg_write)
    begin
      if (reg_addr == addr_pwm_rate_divider)
        pwm_rate_divider <= reg_wdata;
      else if (reg_addr == addr_sample_divider_low)
        sample_divider[7:0] <= reg_wdata;
      else if (reg_addr == addr_sample_divider_high)
        sample_divider[15:8] <= reg_wdata;
      else if (reg_addr == addr_acquisition_constant)
        acquisition_constant <= reg_wdata;
    end
  end

  // ****************************************************************
  // open loop command register
  // ****************************************************************
  // duty update has no done input: it completes in the cycle after it is taken
  assign cmd_done = {3'h0, eeprom_done && cal_store_busy,
    auto_gain_done, capture_offsets_done, capture_readings_done, compute_cal_done};

  always_comb
  begin
    next_commands = open_loop_commands & ~cmd_done;
    if (open_loop_commands[bit_apply_duty])
      next_commands[bit_apply_duty] = 1'b0;
    // a new set wins over a completion in the same cycle
    if (cmd_write && open_loop_select)
      next_commands = next_commands | (reg_wdata & cmd_write_mask);
    if (!open_loop_select)
      next_commands = 8'h00;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      open_loop_commands <= rst_open_loop_commands;
    else
      open_loop_commands <= next_commands;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cal_store_busy <= 1'b0;
    else if (cal_store_start)
      cal_store_busy <= 1'b1;
    else if (eeprom_done)
      cal_store_busy <= 1'b0;
  end

  assign start_edges = set_edges(open_loop_commands, next_commands);
  assign cal_store_start = start_edges[bit_cal_store];
  assign auto_gain_start = start_edges[bit_auto_gain];
  assign capture_offsets_start = start_edges[bit_capture_offsets];
  assign capture_readings_start = start_edges[bit_capture_readings];
  assign compute_cal_start = start_edges[bit_compute_cal];

  // ****************************************************************
  // duty latch
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      red_width <= '0;
      green_width <= '0;
      blue_width <= '0;
    end
    else if (open_loop_commands[bit_apply_duty] && modulator_enable && open_loop_select)
    begin
      red_width <= red_duty;
      green_width <= green_duty;
      blue_width <= blue_duty;
    end
  end

  // ****************************************************************
  // rate generation
  // ****************************************************************
  // period is (divider + 1) * 4096 clocks
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pwm_prescale <= 8'h00;
      pwm_phase <= 12'h000;
    end
    else if (pwm_prescale >= pwm_rate_divider)
    begin
      pwm_prescale <= 8'h00;
      pwm_phase <= pwm_phase + 12'h001;
    end
    else
      pwm_prescale <= pwm_prescale + 8'h01;
  end

  assign pwm_period_tick = (pwm_prescale >= pwm_rate_divider) && (pwm_phase == 12'hfff);

  // a zero divider gives a tick on every clock, a period of one
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      sample_count <= 19'h00000;
    else if (sample_tick)
      sample_count <= 19'h00000;
    else
      sample_count <= sample_count + 19'h00001;
  end

  assign sample_tick = (sample_count + 19'h00001 >= {sample_divider, 3'b000});

  // ****************************************************************
  // pwm outputs
  // ****************************************************************
  pwm_channel #(.width(duty_width)) red_ch (
    .mclk(mclk), .resetn(resetn), .phase(pwm_phase[11 -: duty_width]), .duty(red_width),
    .enable(modulator_enable), .active_low(output_polarity), .pulse(red_pulse_out));
  pwm_channel #(.width(duty_width)) green_ch (
    .mclk(mclk), .resetn(resetn), .phase(pwm_phase[11 -: duty_width]), .duty(green_width),
    .enable(modulator_enable), .active_low(output_polarity), .pulse(green_pulse_out));
  pwm_channel #(.width(duty_width)) blue_ch (
    .mclk(mclk), .resetn(resetn), .phase(pwm_phase[11 -: duty_width]), .duty(blue_width),
    .enable(modulator_enable), .active_low(output_polarity), .pulse(blue_pulse_out));

  // ****************************************************************
  // fault flags
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      fault_flags <= 8'h00;
    else
    begin
      if (acquisition_failed)
        fault_flags[bit_acquisition_fail] <= 1'b1;
      else if (acquisition_ok)
        fault_flags[bit_acquisition_fail] <= 1'b0;
      if (eeprom_ack_fail)
        fault_flags[bit_eeprom_fault] <= 1'b1;
      else if (eeprom_done)
        fault_flags[bit_eeprom_fault] <= 1'b0;
      fault_flags[bit_too_dim] <= light_dim;
      fault_flags[bit_too_bright] <= light_bright;
      fault_flags[bit_setpoint_unlocked] <= setpoint_unlocked;
      fault_flags[bit_out_of_range] <= setpoint_out_of_range;
    end
  end

  // ****************************************************************
  // read back
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      if (reg_addr == addr_open_loop_commands)
        reg_rdata <= open_loop_commands;
      else if (reg_addr == addr_output_config)
        reg_rdata <= output_config;
      else if (reg_addr == addr_loop_mode_select)
        reg_rdata <= loop_mode_select;
      else if (reg_addr == addr_pwm_rate_divider)
        reg_rdata <= pwm_rate_divider;
      else if (reg_addr == addr_sample_divider_low)
        reg_rdata <= sample_divider[7:0];
      else if (reg_addr == addr_sample_divider_high)
        reg_rdata <= sample_divider[15:8];
      else if (reg_addr == addr_mode_flags)
        reg_rdata <= {5'h00, open_loop_select, !open_loop_select, init_flag};
      else if (reg_addr == addr_fault_flags)
        reg_rdata <= fault_flags;
      else if (reg_addr == addr_acquisition_constant)
        reg_rdata <= acquisition_constant;
      else
        reg_rdata <= 8'h00;
    end
  end
endmodule : led_color_ctrl_cmd_status
`default_nettype wire

// >>> tb/led_ctrl_props.sv
// concurrent checks on the colour controller register bank ports
// assumes binding to the top module with one clock and async low reset
`timescale 1ns/1ps
`default_nettype none
module led_ctrl_props
  import led_ctrl_pkg::*;
(
  // clock, reset and register port
  input wire logic mclk,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // engine handshakes
  input wire logic cal_store_start,
  input wire logic self_download_start,
  input wire logic colour_point_fetch,
  input wire logic eeprom_done,
  input wire logic stored_modulator_enable,
  input wire logic auto_gain_start,
  input wire logic capture_offsets_start,
  input wire logic capture_readings_start,
  input wire logic compute_cal_start,
  // loop status and rates
  input wire logic light_dim,
  input wire logic light_bright,
  input wire logic setpoint_unlocked,
  input wire logic setpoint_out_of_range,
  input wire logic pwm_period_tick,
  input wire logic sample_tick,
  input wire logic [15:0] sample_divider
);
  // ****************
  // shadows and period counters
  // ****************
  logic open_mode, self_dl, pval, sval;
  logic [7:0] pdiv;
  logic [15:0] sdiv_q;
  int pcnt, scnt;
  wire logic cmd_wr = reg_write && reg_addr == addr_open_loop_commands;
  wire logic pdiv_wr = reg_write && reg_addr == addr_pwm_rate_divider;
  wire logic [3:0] loop_lv = {light_dim, light_bright, setpoint_unlocked, setpoint_out_of_range};
  wire logic any_start = cal_store_start || auto_gain_start || capture_offsets_start
    || capture_readings_start || compute_cal_start;
  // a period is only judged once a whole one ran with an unchanged divider
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      open_mode <= 1'b0;
      self_dl <= 1'b0;
      pdiv <= 8'h00;
      sdiv_q <= 16'h0000;
      pcnt <= 0;
      scnt <= 0;
      pval <= 1'b0;
      sval <= 1'b0;
    end
    else
    begin
      if (reg_write && reg_addr == addr_loop_mode_select)
        open_mode <= reg_wdata[0];
      if (reg_write && reg_addr == addr_output_config)
        self_dl <= reg_wdata[bit_self_download_en];
      if (pdiv_wr)
        pdiv <= reg_wdata;
      sdiv_q <= sample_divider;
      pcnt <= pwm_period_tick ? 1 : pcnt + 1;
      scnt <= sample_tick ? 1 : scnt + 1;
      pval <= (pwm_period_tick || pval) && !pdiv_wr && !soft_reset;
      sval <= (sample_tick || sval) && sample_divider == sdiv_q && !soft_reset;
    end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_start_cause: assert property (any_start |-> cmd_wr && open_mode)
    else $error("engine start without an open loop command write");
  a_offsets_launch: assert property (cmd_wr && open_mode && reg_wdata[bit_capture_offsets]
    |-> capture_offsets_start) else $error("offset capture not launched");
  a_pwm_period: assert property (pwm_period_tick && pval
    |-> pcnt == (int'(pdiv) + 1) * pwm_counts_per_period) else $error("pwm period wrong");
  a_sample_period: assert property (sample_tick && sval
    |-> scnt == int'(sample_divider) * sample_prescale) else $error("sample period wrong");
  a_mode_flags: assert property (reg_read && reg_addr == addr_mode_flags
    |=> reg_rdata[2:1] == {$past(open_mode), !$past(open_mode)}) else $error("mode flags wrong");
  a_fault_copy: assert property (reg_read && reg_addr == addr_fault_flags
    |=> {reg_rdata[4:3], reg_rdata[1:0]} == $past(loop_lv, 2)) else $error("fault levels wrong");
  a_download_gate: assert property (self_download_start |-> self_dl)
    else $error("download started while disabled");
  a_colour_fetch: assert property (colour_point_fetch |-> eeprom_done && stored_modulator_enable)
    else $error("colour point fetched without stored enable");
endmodule : led_ctrl_props
bind led_color_ctrl_cmd_status led_ctrl_props props_u (.*);
`default_nettype wire

// >>> tb/led_engines_model.sv
// eeprom, sensor and calibration engines seen from the register bank
// each start is answered by a done pulse lat plus one cycles later; fail reports faults
`timescale 1ns/1ps
`default_nettype none
module led_engines_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // bench controls, lat at least one
  input wire logic [7:0] lat,
  input wire logic fail,
  // starts
  input wire logic cal_store_start,
  input wire logic self_download_start,
  input wire logic auto_gain_start,
  input wire logic capture_offsets_start,
  input wire logic capture_readings_start,
  input wire logic compute_cal_start,
  // answers
  output logic eeprom_done,
  output logic eeprom_ack_fail,
  output logic auto_gain_done,
  output logic capture_offsets_done,
  output logic capture_readings_done,
  output logic compute_cal_done,
  output logic acquisition_ok,
  output logic acquisition_failed
);
  // ****************
  // one countdown per engine
  // ****************
  logic [4:0] st, dn;
  logic [7:0] cnt [5];
  assign st = {cal_store_start || self_download_start, auto_gain_start, capture_offsets_start,
    capture_readings_start, compute_cal_start};
  assign {eeprom_done, auto_gain_done, capture_offsets_done, capture_readings_done,
    compute_cal_done} = dn;
  assign eeprom_ack_fail = dn[4] && fail;
  assign acquisition_failed = dn[1] && fail;
  assign acquisition_ok = dn[1] && !fail;
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      dn <= 5'h00;
      for (int i = 0; i < 5; i++)
        cnt[i] <= 8'h00;
    end
    else
      for (int i = 0; i < 5; i++)
      begin
        dn[i] <= cnt[i] == 8'h01;
        cnt[i] <= st[i] ? lat : (cnt[i] != 8'h00 ? cnt[i] - 8'h01 : 8'h00);
      end
endmodule : led_engines_model
`default_nettype wire

// >>> tb/tb_led_color_ctrl_cmd_status.sv
// self-checking bench for the colour controller register bank
// drives inputs at the falling edge; engines answer through led_engines_model
`timescale 1ns/1ps
`default_nettype none
module tb_led_color_ctrl_cmd_status
  import led_ctrl_pkg::*;
  ;
  // ****************
  // signals, instances, helpers
  // ****************
  logic mclk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, soft_reset = 1'b0;
  logic light_dim = 1'b0, light_bright = 1'b0, setpoint_unlocked = 1'b0, setpoint_out_of_range = 1'b0;
  logic fail = 1'b0, stored_modulator_enable = 1'b0, stored_polarity = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, lat = 8'h01, reg_rdata, acquisition_constant, rd_v;
  logic [11:0] red_duty = 12'h000, green_duty = 12'h400, blue_duty = 12'hfff;
  logic cal_store_start, self_download_start, colour_point_fetch, eeprom_done, eeprom_ack_fail;
  logic auto_gain_start, capture_offsets_start, capture_readings_start, compute_cal_start;
  logic auto_gain_done, capture_offsets_done, capture_readings_done, compute_cal_done;
  logic acquisition_ok, acquisition_failed, pwm_period_tick, sample_tick;
  logic red_pulse_out, green_pulse_out, blue_pulse_out;
  logic [15:0] sample_divider;
  int err_total = 0, check_count = 0, n, dl_n = 0, fetch_n = 0;
  led_color_ctrl_cmd_status #(.duty_width(12)) dut_u (.*);
  led_engines_model model_u (.*);
  always #4 mclk = ~mclk;
  always @(negedge mclk)
  begin
    dl_n += self_download_start;
    fetch_n += colour_point_fetch;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
      $display("unexpected at %0t: saw %h, wanted %h (mismatch %0d)", $time, seen, exp, ++err_total);
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge mclk);
    reg_write = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge mclk);
    reg_read = 1'b0;
    rd_v = reg_rdata;
  endtask : rd
  // green high cycles over one 4096-count period at divider 0
  task automatic count_high();
    n = 0;
    repeat (pwm_counts_per_period) @(negedge mclk) n += int'(green_pulse_out);
  endtask : count_high
  // first loop finds a tick, second measures the gap
  task automatic gap_of(input bit pick);
    repeat (2)
    begin
      n = 0;
      do
        @(negedge mclk) n++;
      while ((pick ? sample_tick : pwm_period_tick) !== 1'b1 && n < 40000);
    end
  endtask : gap_of
  task automatic summarize();
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  // ****************
  // scenarios
  // ****************
  task automatic t_reset_values();
    logic [7:0] a [9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h22, 8'h23, 8'ha9};
    logic [7:0] e [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h75, 8'h02, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++)
    begin
      rd(a[i]);
      chk(rd_v, e[i]);
    end
  endtask : t_reset_values
  // reserved bits, read-only and unmapped places ignore writes
  task automatic t_write_back();
    logic [7:0] a [6] = '{8'h03, 8'h05, 8'h06, 8'ha9, 8'h22, 8'h40};
    logic [7:0] d [6] = '{8'hf8, 8'h5a, 8'h31, 8'h09, 8'hff, 8'hff};
    logic [7:0] e [6] = '{8'h00, 8'h5a, 8'h31, 8'h09, 8'h02, 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      wr(a[i], d[i]);
      rd(a[i]);
      chk(rd_v, e[i]);
    end
    chk(acquisition_constant, 8'h09);
  endtask : t_write_back
  task automatic t_rates();
    wr(8'h05, 8'h00);
    gap_of(1'b0);
    chk(n, pwm_counts_per_period);
    wr(8'h05, 8'h01);
    gap_of(1'b0);
    chk(n, 2 * pwm_counts_per_period);
    wr(8'h05, 8'h00);
    wr(8'h07, 8'h08);
    wr(8'h06, 8'h00);
    wr(8'ha9, 8'h00);
    chk(sample_divider, 16'h0800);
    gap_of(1'b1);
    chk(n, 16'h0800 * sample_prescale);
  endtask : t_rates
  task automatic t_commands();
    wr(8'h02, 8'h9f);
    rd(8'h02);
    chk(rd_v, 8'h00);
    wr(8'h04, 8'h01);
    rd(8'h22);
    chk(rd_v, 8'h04);
    wr(8'h03, 8'h01);
    lat = 8'd20;
    fail = 1'b1;
    wr(8'h02, 8'h1f);
    rd(8'h02);
    chk(rd_v, 8'h1f);
    repeat (25) @(negedge mclk);
    rd(8'h02);
    chk(rd_v, 8'h00);
    rd(8'h23);
    chk(rd_v, 8'ha0);
    fail = 1'b0;
    lat = 8'd1;
    wr(8'h02, 8'h12);
    repeat (4) @(negedge mclk);
    rd(8'h23);
    chk(rd_v, 8'h00);
  endtask : t_commands
  task automatic t_duty();
    wr(8'h02, 8'h80);
    repeat (3) @(negedge mclk);
    rd(8'h02);
    chk(rd_v, 8'h00);
    count_high();
    chk(n, 12'h400);
    green_duty = 12'hc00;
    count_high();
    chk(n, 12'h400);
    wr(8'h02, 8'h80);
    repeat (3) @(negedge mclk);
    count_high();
    chk(n, 12'hc00);
    wr(8'h03, 8'h03);
    repeat (3) @(negedge mclk);
    count_high();
    chk(n, 12'h400);
    wr(8'h03, 8'h00);
    repeat (3) @(negedge mclk);
    count_high();
    chk(n, 0);
  endtask : t_duty
  task automatic t_faults();
    for (int i = 0; i < 4; i++)
    begin
      {light_dim, light_bright, setpoint_unlocked, setpoint_out_of_range} = 4'b0001 << i;
      repeat (2) @(negedge mclk);
      rd(8'h23);
      chk(rd_v, {3'b000, 4'b0001 << i} + (i > 1 ? 8'h04 << (i - 2) : 8'h00));
    end
    {light_dim, light_bright, setpoint_unlocked, setpoint_out_of_range} = 4'b0000;
  endtask : t_faults
  task automatic t_download();
    wr(8'h04, 8'h00);
    soft_reset = 1'b1;
    @(negedge mclk) soft_reset = 1'b0;
    repeat (30) @(negedge mclk);
    chk(dl_n, 0);
    wr(8'h03, 8'h07);
    {stored_modulator_enable, stored_polarity, lat} = {2'b11, 8'd20};
    soft_reset = 1'b1;
    @(negedge mclk) soft_reset = 1'b0;
    rd(8'h22);
    chk(rd_v[0], 1'b1);
    repeat (30) @(negedge mclk);
    rd(8'h22);
    chk(rd_v, 8'h02);
    rd(8'h03);
    chk(rd_v, 8'h07);
    chk(dl_n, 1);
    chk(fetch_n, 1);
  endtask : t_download
  initial
  begin
    #(8ns * 95000);
    err_total++;
    summarize();
  end
  initial
  begin
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    t_reset_values();
    t_write_back();
    t_rates();
    t_commands();
    t_duty();
    t_faults();
    t_download();
    summarize();
  end
endmodule : tb_led_color_ctrl_cmd_status
`default_nettype wire
